// ---- hdl/udw_regs.svh ----
// Register offsets, field positions and reset values of the data word port
`ifndef UDW_REGS_SVH
`define UDW_REGS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define UDW_ADDR_W 8
`define UDW_OFS_DATA 8'h00
`define UDW_OFS_CTRL 8'h04
`define UDW_OFS_ISTAT 8'h08
`define UDW_OFS_IMASK 8'h0c
`define UDW_OFS_PSTAT 8'h10

// ------------------------------------------------------------
// Data word fields
// ------------------------------------------------------------
`define UDW_BIT_RX_NOISE_FLAG 15
`define UDW_BIT_PARITY 14
`define UDW_BIT_FRAME_SPECIAL 13
`define UDW_BIT_EMPTY 12
`define UDW_BIT_IDLE 11
`define UDW_BIT_RSVD 10
`define UDW_BIT_NINE 9
`define UDW_WORD_W 10

// ------------------------------------------------------------
// Control, interrupt and port status fields
// ------------------------------------------------------------
`define UDW_CTRL_RXEN 0
`define UDW_EV_W 4
`define UDW_EV_RX_WORD 0
`define UDW_EV_RX_OVERRUN 1
`define UDW_EV_TX_TAKEN 2
`define UDW_EV_TX_REFUSED 3
`define UDW_PSTAT_RX_FULL 0
`define UDW_PSTAT_TX_FULL 1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define UDW_RST_CTRL 1'h0
`define UDW_RST_EV 4'h0
`define UDW_RST_RDATA 32'h0000_0000

`endif

// ---- hdl/udw_pkg.sv ----
// Types shared by the data word port and its receive word store
`default_nettype none

package udw_pkg;

  // ------------------------------------------------------------
  // Received word with its per-word status
  // ------------------------------------------------------------
  typedef struct packed {
    logic rx_noise_flag;
    logic parityErr;
    logic frameErr;
    logic idleBefore;
    logic [9:0] bits;
  } udw_rx_word_t;

  // ------------------------------------------------------------
  // Word queued for the transmitter
  // ------------------------------------------------------------
  typedef struct packed {
    logic special;
    logic idleChar;
    logic [9:0] bits;
  } udw_tx_word_t;

endpackage : udw_pkg

`default_nettype wire

// ---- hdl/udw_rx_hold.sv ----
// One-word store for the received word and its status
`default_nettype none

module udw_rx_hold (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic load,
  input wire udw_pkg::udw_rx_word_t loadWord,
  output udw_pkg::udw_rx_word_t word_q
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Status and data are latched as one unit and never touched apart
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      word_q <= '0;
    end else if (ce && load) begin
      word_q <= loadWord;
    end
  end

endmodule : udw_rx_hold

`default_nettype wire

// ---- hdl/udw_data_port.sv ----
// Data word access port between register port and transmit/receive buffers
//
// Function
// - Bit 14 reads 1 when the held word had a parity error.
// - Bit 13 reads 1 when the held word had a frame error.
// - Write with bit 13 set queues break or idle instead of data.
// - Special character: bit 9 low sends break, high sends idle.
// - Bit 12 reads 1 when receive buffer is empty, shifter ignored.
// - With bit 12 set the returned data bits are not valid.
// - Bit 11 reads 1 when the line was idle before the held word.
// - Idle-before indication may set for first word after receiver enable.
// - Bit 10 always reads zero and writes to it do nothing.
// - Bits 9..0 read receive buffer and write transmit buffer.
// - Reads take the receive buffer, writes load transmit; neither clears the event flags.
// - Bit 15 reads 1 when the held word was sampled with noise.
//
// The plain strobed port and the register addresses were decided locally.
`include "udw_regs.svh"
`default_nettype none

module udw_data_port (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [`UDW_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata_q,
  input wire logic rxCapture,
  input wire udw_pkg::udw_rx_word_t rxWord,
  input wire logic rxLineIdle,
  input wire logic txTake,
  output logic txValid_q,
  output udw_pkg::udw_tx_word_t txWord_q,
  output logic rxEnable_q,
  output logic irq_q
);

  // ------------------------------------------------------------
  // Local state
  // ------------------------------------------------------------
  logic rxFull_q;
  logic rxFull_d;
  logic rxEnPrev_q;
  logic idleSeen_q;
  logic idleSeen_d;
  logic [`UDW_EV_W-1:0] evStat_q;
  logic [`UDW_EV_W-1:0] evStat_d;
  logic [`UDW_EV_W-1:0] evMask_q;
  logic [`UDW_EV_W-1:0] evSet;
  logic [`UDW_EV_W-1:0] evClr;
  logic rxEnRise;
  logic rxOverrun;
  logic txTaken;
  logic [31:0] regRdata_d;
  udw_pkg::udw_rx_word_t heldWord;
  udw_pkg::udw_rx_word_t captWord;
  udw_pkg::udw_tx_word_t txWord_d;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic hit(
    input logic [`UDW_ADDR_W-1:0] addr,
    input logic [`UDW_ADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction : hit

  logic dataRd;
  logic dataWr;
  logic ctrlWr;
  logic istatWr;
  logic imaskWr;
  logic rxPop;
  logic rxAccept;
  logic txAccept;
  logic txRefused;

  assign dataRd = regRd && hit(regAddr, `UDW_OFS_DATA);
  assign dataWr = regWr && hit(regAddr, `UDW_OFS_DATA);
  assign ctrlWr = regWr && hit(regAddr, `UDW_OFS_CTRL);
  assign istatWr = regWr && hit(regAddr, `UDW_OFS_ISTAT);
  assign imaskWr = regWr && hit(regAddr, `UDW_OFS_IMASK);

  // ------------------------------------------------------------
  // Receive buffer handshake
  // ------------------------------------------------------------
  // A read of the data word frees the buffer; shifter contents do not count
  assign rxPop = dataRd && rxFull_q;
  // A word arriving in the pop cycle replaces the popped one
  assign rxAccept = rxCapture && (!rxFull_q || rxPop);
  // Overrun keeps the older word, so software sees words in arrival order
  assign rxOverrun = rxCapture && !rxAccept;

  always_comb begin
    rxFull_d = rxFull_q;
    if (rxAccept) begin
      rxFull_d = 1'b1;
    end else if (rxPop) begin
      rxFull_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxFull_q <= 1'b0;
    end else if (ce) begin
      rxFull_q <= rxFull_d;
    end
  end

  // ------------------------------------------------------------
  // Idle-before-character tracking
  // ------------------------------------------------------------
  // Enabling the receiver counts as a quiet line, so the first word after
  // enable may carry the idle indication; the separate idle flag cannot
  assign rxEnRise = rxEnable_q && !rxEnPrev_q;

  // A capture clears last: an idle already counted for this word must not
  // mark the next one as well
  always_comb begin
    idleSeen_d = idleSeen_q;
    if (rxEnRise) begin
      idleSeen_d = 1'b1;
    end
    if (rxLineIdle) begin
      idleSeen_d = 1'b1;
    end
    if (rxCapture) begin
      idleSeen_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idleSeen_q <= 1'b0;
    end else if (ce) begin
      idleSeen_q <= idleSeen_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxEnPrev_q <= 1'b0;
    end else if (ce) begin
      rxEnPrev_q <= rxEnable_q;
    end
  end

  always_comb begin
    captWord = rxWord;
    captWord.idleBefore = idleSeen_q || rxLineIdle;
  end

  // ------------------------------------------------------------
  // Received word store
  // ------------------------------------------------------------
  udw_rx_hold uRxHold (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .load(rxAccept),
    .loadWord(captWord),
    .word_q(heldWord)
  );

  // ------------------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------------------
  // A write while the buffer still holds a word is dropped, never merged,
  // so a character already queued is not corrupted
  assign txAccept = dataWr && (!txValid_q || txTake);
  assign txRefused = dataWr && !txAccept;
  // A take only counts while a word is actually waiting
  assign txTaken = txTake && txValid_q;

  // Data bits pass as written even for a special character; zeroing them
  // is left to software
  function automatic udw_pkg::udw_tx_word_t txFromWrite(
    input logic [31:0] wdata
  );
    udw_pkg::udw_tx_word_t t;
    t = '0;
    t.bits = wdata[`UDW_BIT_NINE:0];
    t.special = wdata[`UDW_BIT_FRAME_SPECIAL];
    t.idleChar = wdata[`UDW_BIT_FRAME_SPECIAL] &&
      wdata[`UDW_BIT_NINE];
    txFromWrite = t;
  endfunction : txFromWrite

  always_comb begin
    txWord_d = txWord_q;
    if (txAccept) begin
      txWord_d = txFromWrite(regWdata);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txWord_q <= '0;
    end else if (ce) begin
      txWord_q <= txWord_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txValid_q <= 1'b0;
    end else if (ce) begin
      if (txAccept) begin
        txValid_q <= 1'b1;
      end else if (txTake) begin
        txValid_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxEnable_q <= `UDW_RST_CTRL;
    end else if (ce && ctrlWr) begin
      rxEnable_q <= regWdata[`UDW_CTRL_RXEN];
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  always_comb begin
    evSet = '0;
    evSet[`UDW_EV_RX_WORD] = rxAccept;
    evSet[`UDW_EV_RX_OVERRUN] = rxOverrun;
    evSet[`UDW_EV_TX_TAKEN] = txTaken;
    evSet[`UDW_EV_TX_REFUSED] = txRefused;
  end

  // Only a write to the status word clears; ones written elsewhere are inert
  assign evClr = istatWr ? regWdata[`UDW_EV_W-1:0] : {`UDW_EV_W{1'b0}};

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    evStat_d = evStat_q & ~evClr;
    evStat_d = evStat_d | evSet;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evStat_q <= `UDW_RST_EV;
    end else if (ce) begin
      evStat_q <= evStat_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evMask_q <= `UDW_RST_EV;
    end else if (ce && imaskWr) begin
      evMask_q <= regWdata[`UDW_EV_W-1:0];
    end
  end

  // Registered from the next status, so the line changes in the same cycle as the status
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(evStat_d & evMask_q);
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  function automatic logic [31:0] dataView(
    input udw_pkg::udw_rx_word_t w,
    input logic full
  );
    logic [31:0] v;
    v = '0;
    if (full) begin
      v[`UDW_BIT_RX_NOISE_FLAG] = w.rx_noise_flag;
      v[`UDW_BIT_PARITY] = w.parityErr;
      v[`UDW_BIT_FRAME_SPECIAL] = w.frameErr;
      v[`UDW_BIT_IDLE] = w.idleBefore;
      v[`UDW_BIT_NINE:0] = w.bits;
    end
    // Empty buffer returns zeros, which carry no character
    v[`UDW_BIT_EMPTY] = !full;
    v[`UDW_BIT_RSVD] = 1'b0;
    dataView = v;
  endfunction : dataView

  // Event registers share one layout in the low bits of the word
  function automatic logic [31:0] evView(
    input logic [`UDW_EV_W-1:0] ev
  );
    logic [31:0] v;
    v = '0;
    v[`UDW_EV_W-1:0] = ev;
    evView = v;
  endfunction : evView

  always_comb begin
    regRdata_d = `UDW_RST_RDATA;
    if (regRd) begin
      case (regAddr)
        `UDW_OFS_DATA: begin
          regRdata_d = dataView(heldWord, rxFull_q);
        end
        `UDW_OFS_CTRL: begin
          regRdata_d[`UDW_CTRL_RXEN] = rxEnable_q;
        end
        `UDW_OFS_ISTAT: begin
          regRdata_d = evView(evStat_q);
        end
        `UDW_OFS_IMASK: begin
          regRdata_d = evView(evMask_q);
        end
        `UDW_OFS_PSTAT: begin
          regRdata_d[`UDW_PSTAT_RX_FULL] = rxFull_q;
          regRdata_d[`UDW_PSTAT_TX_FULL] = txValid_q;
        end
        default: begin
          regRdata_d = `UDW_RST_RDATA;
        end
      endcase
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata_q <= `UDW_RST_RDATA;
    end else if (ce) begin
      regRdata_q <= regRdata_d;
    end
  end

endmodule : udw_data_port

`default_nettype wire

// ---- verification/udw_data_port_chk.sv ----
// Concurrent checks on the data word port
`include "udw_regs.svh"
`default_nettype none

module udw_data_port_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [`UDW_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata_q,
  input wire logic rxCapture,
  input wire udw_pkg::udw_rx_word_t rxWord,
  input wire logic rxLineIdle,
  input wire logic txTake,
  input wire logic txValid_q,
  input wire udw_pkg::udw_tx_word_t txWord_q,
  input wire logic rxEnable_q,
  input wire logic irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_rsvd_zero: assert property (
    regRdata_q[31:16] == 16'h0 && !regRdata_q[10]
  ) else $error("reserved read bits set");
  a_empty_clear: assert property (
    regRdata_q[12] |-> regRdata_q[15:0] == 16'h1000
  ) else $error("empty read carries data");
  a_tx_load: assert property (
    ce && regWr && regAddr == `UDW_OFS_DATA && (!txValid_q || txTake)
    |=> txValid_q && txWord_q == {$past(regWdata[13]),
      $past(regWdata[13]) & $past(regWdata[9]), $past(regWdata[9:0])}
  ) else $error("transmit word not loaded");
  a_tx_hold: assert property (
    ce && txValid_q && !txTake |=> txValid_q && $stable(txWord_q)
  ) else $error("pending transmit word changed");
  a_tx_take: assert property (
    ce && txValid_q && txTake && !(regWr && regAddr == `UDW_OFS_DATA)
    |=> !txValid_q
  ) else $error("transmit buffer not freed");
  a_rd_stands: assert property (
    ce && !regRd |=> regRdata_q == 32'h0
  ) else $error("read data outside answer cycle");
  a_pop_empty: assert property (
    ce && regRd && regAddr == `UDW_OFS_DATA && !rxCapture
    ##1 ce && regRd && regAddr == `UDW_OFS_DATA |=> regRdata_q[12]
  ) else $error("buffer not empty after pop");
  a_rxen_set: assert property (
    ce && regWr && regAddr == `UDW_OFS_CTRL
    |=> rxEnable_q == $past(regWdata[0])
  ) else $error("receiver enable not written");
  a_unmapped_rd: assert property (
    ce && regRd && regAddr == 8'h20 |=> regRdata_q == 32'h0
  ) else $error("unmapped read not zero");
  a_irq_masked: assert property (
    ce && regWr && regAddr == `UDW_OFS_IMASK && regWdata[3:0] == 4'h0
    ##1 ce && !(regWr && regAddr == `UDW_OFS_IMASK) |=> !irq_q
  ) else $error("interrupt while all masked");
endmodule : udw_data_port_chk

bind udw_data_port udw_data_port_chk i_udw_data_port_chk (.mclk, .arst_n,
  .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata_q, .rxCapture,
  .rxWord, .rxLineIdle, .txTake, .txValid_q, .txWord_q, .rxEnable_q,
  .irq_q);
`default_nettype wire

// ---- verification/udw_far_model.sv ----
// Far-side serial partner: feeds received words, drains the transmit word
`default_nettype none

module udw_far_model (
  input wire logic mclk,
  input wire logic txValid_q,
  input wire udw_pkg::udw_tx_word_t txWord_q,
  output logic rxCapture,
  output udw_pkg::udw_rx_word_t rxWord,
  output logic rxLineIdle,
  output logic txTake
);
  timeunit 1ns;
  timeprecision 1ps;
  int takeWait = 0;
  int waitCnt = 0;

  initial begin
    rxCapture = 1'b0;
    rxWord = '1;
    rxLineIdle = 1'b0;
    txTake = 1'b0;
  end

  // Word lines show the inverse off the capture cycle, so a late
  // sample cannot match by luck
  task automatic send(input udw_pkg::udw_rx_word_t w, input logic idle);
    rxCapture <= 1'b1;
    rxWord <= w;
    rxLineIdle <= idle;
    @(posedge mclk);
    rxCapture <= 1'b0;
    rxWord <= ~w;
    rxLineIdle <= 1'b0;
  endtask : send

  // Shifter takes the word after takeWait cycles; a large value stalls
  always @(posedge mclk) begin
    txTake <= 1'b0;
    waitCnt <= 0;
    if (txValid_q && !txTake) begin
      if (waitCnt >= takeWait) begin
        txTake <= 1'b1;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule : udw_far_model
`default_nettype wire

// ---- verification/udw_data_port_tb.sv ----
// Self-checking bench of the data word port
`include "udw_regs.svh"
`default_nettype none

module udw_data_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata_q;
  logic rxCapture, rxLineIdle, txTake, txValid_q, rxEnable_q, irq_q;
  udw_pkg::udw_rx_word_t rxWord;
  udw_pkg::udw_tx_word_t txWord_q;
  logic [31:0] txIn[3] = '{32'h2000, 32'h2200, 32'h0401};
  logic [31:0] txExp[3] = '{32'h800, 32'he00, 32'h001};
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  udw_data_port i_udw_data_port (.mclk, .arst_n, .ce, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata_q, .rxCapture, .rxWord, .rxLineIdle, .txTake,
    .txValid_q, .txWord_q, .rxEnable_q, .irq_q);
  udw_far_model i_udw_far_model (.mclk, .txValid_q, .txWord_q, .rxCapture,
    .rxWord, .rxLineIdle, .txTake);

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A gap cycle follows each access so no strobe is driven twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk(regRdata_q, exp);
    @(posedge mclk);
  endtask : rd

  task automatic irqIs(input logic exp);
    @(negedge mclk);
    chk({31'h0, irq_q}, {31'h0, exp});
    @(posedge mclk);
  endtask : irqIs

  task automatic drain();
    for (int i = 0; i < 20 && txValid_q; i++) @(posedge mclk);
    chk({31'h0, txValid_q}, 32'h0);
  endtask : drain

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd(`UDW_OFS_CTRL, 32'h0);
    rd(`UDW_OFS_ISTAT, 32'h0);
    rd(`UDW_OFS_IMASK, 32'h0);
    rd(`UDW_OFS_PSTAT, 32'h0);
    rd(`UDW_OFS_DATA, 32'h1000);
    rd(8'h20, 32'h0);
    ce <= 1'b0;
    wr(`UDW_OFS_CTRL, 32'h1);
    ce <= 1'b1;
    rd(`UDW_OFS_CTRL, 32'h0);
    wr(`UDW_OFS_CTRL, 32'h1);
    chk({31'h0, rxEnable_q}, 32'h1);
    i_udw_far_model.send(14'h2bff, 1'b0);
    rd(`UDW_OFS_PSTAT, 32'h1);
    i_udw_far_model.send(14'h0155, 1'b0);
    rd(`UDW_OFS_ISTAT, 32'h3);
    // Back-to-back reads: the first pops the word, the second finds none
    regAddr <= `UDW_OFS_DATA;
    regRd <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk(regRdata_q, 32'habff);
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk(regRdata_q, 32'h1000);
    @(posedge mclk);
    wr(`UDW_OFS_IMASK, 32'h4);
    irqIs(1'b0);
    wr(`UDW_OFS_IMASK, 32'h1);
    irqIs(1'b1);
    wr(`UDW_OFS_IMASK, 32'h0);
    irqIs(1'b0);
    wr(`UDW_OFS_IMASK, 32'h1);
    wr(`UDW_OFS_ISTAT, 32'h1);
    irqIs(1'b0);
    rd(`UDW_OFS_ISTAT, 32'h2);
    wr(`UDW_OFS_ISTAT, 32'h2);
    i_udw_far_model.send(14'h1155, 1'b1);
    rd(`UDW_OFS_DATA, 32'h4955);
    i_udw_far_model.send(14'h06aa, 1'b0);
    rd(`UDW_OFS_DATA, 32'h02aa);
    wr(`UDW_OFS_ISTAT, 32'hf);
    i_udw_far_model.takeWait <= 1000;
    wr(`UDW_OFS_DATA, 32'h00a5);
    chk({20'h0, txWord_q}, 32'h0a5);
    rd(`UDW_OFS_PSTAT, 32'h2);
    wr(`UDW_OFS_DATA, 32'h2200);
    chk({20'h0, txWord_q}, 32'h0a5);
    rd(`UDW_OFS_ISTAT, 32'h8);
    i_udw_far_model.takeWait <= 0;
    drain();
    rd(`UDW_OFS_ISTAT, 32'hc);
    for (int i = 0; i < 3; i++) begin
      wr(`UDW_OFS_DATA, txIn[i]);
      chk({20'h0, txWord_q}, txExp[i]);
      drain();
    end
    wrap_up();
  end
endmodule : udw_data_port_tb
`default_nettype wire
